// [rtl/tlpiu_top.sv]
// tlpiu_top: two-level priority interrupt unit with apb registers.
// assumes: core sequencer acknowledges vectors and signals return
// from interrupt with one-cycle pulses; pins synchronous to i_mclk.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps

// Functional notes
// - high vector 0008h, low vector 0018h
// - high request preempts low routine
// - each source has flag and enable; all but external input 3 have priority
// - priority mode only when reset-control bit7 set
// - high enable gates high-priority sources
// - low enable gates low-priority sources
// - flag, enable, global enable vector at once
// - compatibility mode vectors everything to 0008h
// - compatibility bit6 gates peripheral sources
// - compatibility bit7 gates every source
// - accepted request clears its admitting enable
// - no low requests during high routine
// - push return address, load vector address
// - return sets the cleared enable again
// - external event to vector three cycles
// - flags set regardless of enables
// - external control register at FF0h
module tlpiu_top
   import tlpiu_pkg::*;
#(
   parameter int NPER = 8
)
(
   input  wire logic            i_mclk,
   input  wire logic            i_arst_n,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     o_prdata,
   output logic                 o_pready,
   output logic                 o_pslverr,
   input  wire logic [2:0]      i_ext_pin,
   input  wire logic [NPER-1:0] i_periph_event,
   input  wire logic [20:0]     i_return_addr,
   input  wire logic            i_vec_ack,
   input  wire logic            i_return_from_irq_op,
   output tlpiu_vec_type        o_vec,
   output logic                 o_stack_push,
   output logic      [20:0]     o_stack_data
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0]      ext_ctrl;
      logic [7:0]      irq_ctrl;
      logic            prio_on;
      logic [NPER-1:0] pflag;
      logic [NPER-1:0] pen;
      logic [NPER-1:0] pprio;
      logic            in_high;
      logic            in_low;
      logic [1:0]      lat;
      tlpiu_state_type st;
      tlpiu_vec_type   vec;
      logic            push;
      logic [20:0]     sdata;
      logic [31:0]     prdata;
      logic            pready;
      logic            pslverr;
   } tlpiu_regs_type;

   tlpiu_regs_type r;
   tlpiu_regs_type next_r;
   logic [2:0]     ext_rise;

   tlpiu_sync_edge #(.N(3)) u_edge
   (
      .i_mclk  (i_mclk),
      .i_arst_n(i_arst_n),
      .i_pin   (i_ext_pin),
      .o_rise  (ext_rise)
   );

   // decode used by both write and read paths
   function automatic logic is_reg(input logic [11:0] a,
                                   input logic [11:0] off);
      return a == off;
   endfunction

   // ------------------------------------------------------------
   // request evaluation
   // ------------------------------------------------------------
   logic [2:0]      ext_en;
   logic [2:0]      ext_fl;
   logic [2:0]      ext_pr;
   logic            req_hi;
   logic            req_lo;
   logic            ext_pend;
   logic            any_req;
   logic            acc;
   logic            acc_wr;
   logic [NPER-1:0] per_act;

   always_comb
   begin
      ext_en  = r.ext_ctrl[5:3];
      ext_fl  = r.ext_ctrl[2:0];
      // input 3 has no priority select; treated as high level
      ext_pr  = {1'b1, r.ext_ctrl[7:6]};
      per_act = r.pflag & r.pen;
      ext_pend = |(ext_en & ext_fl);
      if (r.prio_on)
      begin
         req_hi = r.irq_ctrl[TLPIU_BIT_HIGH_EN] &
                  (|(ext_en & ext_fl & ext_pr) |
                   |(per_act & r.pprio));
         req_lo = r.irq_ctrl[TLPIU_BIT_LOW_EN] & !r.in_high &
                  (|(ext_en & ext_fl & ~ext_pr) |
                   |(per_act & ~r.pprio));
      end
      else
      begin
         req_hi = r.irq_ctrl[TLPIU_BIT_HIGH_EN] &
                  (ext_pend |
                   (r.irq_ctrl[TLPIU_BIT_LOW_EN] & |per_act));
         req_lo = 1'b0;
      end
      any_req = req_hi | req_lo;
      acc     = r.vec.req & i_vec_ack;
      acc_wr  = psel & penable & pwrite;
   end

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      next_r         = r;
      next_r.push    = 1'b0;
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;

      // hardware sets flags from events whatever the enables
      // register writes first so a same-cycle event still wins
      // write lands at the edge where the master sees pready high
      if (acc_wr && r.pready)
      begin
         if (is_reg(paddr, TLPIU_OFF_EXT_CTRL))
            next_r.ext_ctrl = pwdata[7:0];
         else if (is_reg(paddr, TLPIU_OFF_IRQ_CTRL))
            next_r.irq_ctrl = pwdata[7:0];
         else if (is_reg(paddr, TLPIU_OFF_RST_CTRL))
            next_r.prio_on = pwdata[TLPIU_BIT_PRIO_ON];
         else if (is_reg(paddr, TLPIU_OFF_PER_FLAG))
            next_r.pflag = pwdata[NPER-1:0];
         else if (is_reg(paddr, TLPIU_OFF_PER_EN))
            next_r.pen = pwdata[NPER-1:0];
         else if (is_reg(paddr, TLPIU_OFF_PER_PRIO))
            next_r.pprio = pwdata[NPER-1:0];
      end
      next_r.ext_ctrl[2:0] = next_r.ext_ctrl[2:0] | ext_rise;
      next_r.pflag = next_r.pflag | i_periph_event;

      // apb answer in the cycle after the access phase begins
      if (psel && penable && !r.pready)
      begin
         next_r.pready = 1'b1;
         next_r.prdata = '0;
         if (is_reg(paddr, TLPIU_OFF_EXT_CTRL))
            next_r.prdata[7:0] = r.ext_ctrl;
         else if (is_reg(paddr, TLPIU_OFF_IRQ_CTRL))
            next_r.prdata[7:0] = r.irq_ctrl;
         else if (is_reg(paddr, TLPIU_OFF_RST_CTRL))
            next_r.prdata[TLPIU_BIT_PRIO_ON] = r.prio_on;
         else if (is_reg(paddr, TLPIU_OFF_PER_FLAG))
            next_r.prdata[NPER-1:0] = r.pflag;
         else if (is_reg(paddr, TLPIU_OFF_PER_EN))
            next_r.prdata[NPER-1:0] = r.pen;
         else if (is_reg(paddr, TLPIU_OFF_PER_PRIO))
            next_r.prdata[NPER-1:0] = r.pprio;
         else if (is_reg(paddr, TLPIU_OFF_STATUS))
            next_r.prdata[1:0] = {r.in_high, r.in_low};
         else
            next_r.pslverr = 1'b1;
      end

      // fixed latency so one- and two-cycle instructions match
      case (r.st)
         TLPIU_ST_IDLE:
         begin
            if (any_req)
            begin
               next_r.lat = TLPIU_EXT_LAT - 2'h1;
               next_r.st  = TLPIU_ST_WAIT;
            end
         end
         TLPIU_ST_WAIT:
         begin
            if (!any_req)
               next_r.st = TLPIU_ST_IDLE;
            else if (r.lat == 2'h1)
            begin
               next_r.st       = TLPIU_ST_VEC;
               next_r.vec.req  = 1'b1;
               next_r.vec.high = req_hi;
               next_r.vec.addr = req_hi ? TLPIU_VEC_HIGH
                                        : TLPIU_VEC_LOW;
            end
            else
               next_r.lat = r.lat - 2'h1;
         end
         TLPIU_ST_VEC:
         begin
            if (acc)
            begin
               next_r.vec.req = 1'b0;
               next_r.st      = TLPIU_ST_IDLE;
               next_r.push    = 1'b1;
               next_r.sdata   = i_return_addr;
               if (!r.prio_on || r.vec.high)
               begin
                  next_r.irq_ctrl[TLPIU_BIT_HIGH_EN] = 1'b0;
                  next_r.in_high = 1'b1;
               end
               else
               begin
                  next_r.irq_ctrl[TLPIU_BIT_LOW_EN] = 1'b0;
                  next_r.in_low = 1'b1;
               end
            end
         end
         default:
            next_r.st = TLPIU_ST_IDLE;
      endcase

      // return restores the enable of the innermost level
      if (i_return_from_irq_op && !acc)
      begin
         if (r.in_high)
         begin
            next_r.in_high = 1'b0;
            next_r.irq_ctrl[TLPIU_BIT_HIGH_EN] = 1'b1;
         end
         else if (r.in_low)
         begin
            next_r.in_low = 1'b0;
            next_r.irq_ctrl[TLPIU_BIT_LOW_EN] = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         r          <= '0;
         r.ext_ctrl <= TLPIU_EXT_CTRL_RST;
         r.st       <= TLPIU_ST_IDLE;
      end
      else
         r <= next_r;
   end

   assign o_prdata     = r.prdata;
   assign o_pready     = r.pready;
   assign o_pslverr    = r.pslverr;
   assign o_vec        = r.vec;
   assign o_stack_push = r.push;
   assign o_stack_data = r.sdata;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_vec_addr;
      @(posedge i_mclk) disable iff (!i_arst_n)
      o_vec.req |-> (o_vec.high && o_vec.addr == TLPIU_VEC_HIGH) ||
                    (!o_vec.high && o_vec.addr == TLPIU_VEC_LOW);
   endproperty
   a_vec_addr: assert property (p_vec_addr)
      else $error("vector address does not match level");

   property p_compat_high;
      @(posedge i_mclk) disable iff (!i_arst_n)
      (o_vec.req && !r.prio_on) |-> o_vec.addr == TLPIU_VEC_HIGH;
   endproperty
   a_compat_high: assert property (p_compat_high)
      else $error("compatibility vector not 0008h");

   property p_ack_clears;
      @(posedge i_mclk) disable iff (!i_arst_n)
      (acc && o_vec.high && !i_return_from_irq_op) |=>
         !r.irq_ctrl[TLPIU_BIT_HIGH_EN] && r.in_high;
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("accepted high request left enable set");

   property p_push;
      @(posedge i_mclk) disable iff (!i_arst_n)
      acc |=> o_stack_push && o_stack_data == $past(i_return_addr);
   endproperty
   a_push: assert property (p_push)
      else $error("return address not pushed");

   property p_no_low_in_high;
      @(posedge i_mclk) disable iff (!i_arst_n)
      (r.in_high && $rose(o_vec.req)) |-> o_vec.high;
   endproperty
   a_no_low_in_high: assert property (p_no_low_in_high)
      else $error("low request vectored during high routine");

   property p_latency;
      @(posedge i_mclk) disable iff (!i_arst_n)
      (r.st == TLPIU_ST_IDLE && any_req) ##1 any_req ##1 any_req
         |=> o_vec.req;
   endproperty
   a_latency: assert property (p_latency)
      else $error("vector not raised after fixed latency");

   property p_flag_set;
      @(posedge i_mclk) disable iff (!i_arst_n)
      |i_periph_event |=> (r.pflag & $past(i_periph_event)) ==
                          $past(i_periph_event);
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("peripheral flag lost an event");

   property p_return;
      @(posedge i_mclk) disable iff (!i_arst_n)
      (i_return_from_irq_op && !acc && r.in_low && !r.in_high) |=>
         r.irq_ctrl[TLPIU_BIT_LOW_EN] && !r.in_low;
   endproperty
   a_return: assert property (p_return)
      else $error("return did not restore low enable");

   property p_high_first;
      @(posedge i_mclk) disable iff (!i_arst_n)
      (r.st == TLPIU_ST_WAIT && r.lat == 2'h1 && req_hi) |=>
         o_vec.req && o_vec.high;
   endproperty
   a_high_first: assert property (p_high_first)
      else $error("high request not served first");
endmodule

// [rtl/tlpiu_pkg.sv]
// tlpiu_pkg: constants, register map and carrier types for the
// two-level priority interrupt unit.
// assumes: apb slave with 32-bit data, one word per register.
package tlpiu_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] TLPIU_OFF_EXT_CTRL   = 12'hFF0;
   localparam logic [11:0] TLPIU_OFF_IRQ_CTRL   = 12'hFF4;
   localparam logic [11:0] TLPIU_OFF_RST_CTRL   = 12'hFF8;
   localparam logic [11:0] TLPIU_OFF_PER_FLAG   = 12'hFE0;
   localparam logic [11:0] TLPIU_OFF_PER_EN     = 12'hFE4;
   localparam logic [11:0] TLPIU_OFF_PER_PRIO   = 12'hFE8;
   localparam logic [11:0] TLPIU_OFF_STATUS     = 12'hFEC;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int          TLPIU_BIT_HIGH_EN    = 7;
   localparam int          TLPIU_BIT_LOW_EN     = 6;
   localparam int          TLPIU_BIT_PRIO_ON    = 7;
   localparam logic [7:0]  TLPIU_EXT_CTRL_RST   = 8'hC0;
   localparam logic [7:0]  TLPIU_ZERO8          = 8'h00;

   // ------------------------------------------------------------
   // vectors and latency in core cycles
   // ------------------------------------------------------------
   localparam logic [20:0] TLPIU_VEC_HIGH       = 21'h000008;
   localparam logic [20:0] TLPIU_VEC_LOW        = 21'h000018;
   localparam logic [1:0]  TLPIU_EXT_LAT        = 2'h3;

   typedef enum logic [1:0]
   {
      TLPIU_ST_IDLE = 2'b00,
      TLPIU_ST_WAIT = 2'b01,
      TLPIU_ST_VEC  = 2'b10
   } tlpiu_state_type;

   // vector request toward the core sequencer
   typedef struct packed
   {
      logic        req;
      logic        high;
      logic [20:0] addr;
   } tlpiu_vec_type;

endpackage

// [rtl/tlpiu_sync_edge.sv]
// tlpiu_sync_edge: rising edge detector for external pins.
// assumes: pins already synchronous to i_mclk.
`timescale 1ns/100ps
module tlpiu_sync_edge
#(
   parameter int N = 3
)
(
   input  wire logic         i_mclk,
   input  wire logic         i_arst_n,
   input  wire logic [N-1:0] i_pin,
   output logic      [N-1:0] o_rise
);
   typedef struct packed
   {
      logic [N-1:0] last;
      logic [N-1:0] rise;
   } tlpiu_edge_regs_type;

   tlpiu_edge_regs_type r;
   tlpiu_edge_regs_type next_r;

   // ------------------------------------------------------------
   // one-cycle pulse per rising edge
   // ------------------------------------------------------------
   // pins idle low, so a zero reset value gives no false edge
   always_comb
   begin
      next_r.last = i_pin;
      next_r.rise = i_pin & ~r.last;
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         r <= '0;
      else
         r <= next_r;
   end

   assign o_rise = r.rise;
endmodule

// [dv/tlpiu_core_model.sv]
// tlpiu_core_model: core sequencer facing the interrupt unit.
// assumes: vector held until ack; bench asks for returns.
`timescale 1ns/100ps
module tlpiu_core_model
   import tlpiu_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_arst_n,
   input  tlpiu_vec_type    i_vec,
   input  wire logic [3:0]  i_ack_wait,
   input  wire logic        i_ret_cmd,
   output logic             o_vec_ack,
   output logic             o_ret,
   output logic      [20:0] o_return_addr
);
   logic [3:0] wait_cnt;

   // ------------------------------------------------------------
   // acknowledge and return
   // ------------------------------------------------------------
   // settable ack delay so a slow core holds the vector pending;
   // return address moves on each return to catch stale pushes
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         wait_cnt      <= 4'h0;
         o_vec_ack     <= 1'b0;
         o_ret         <= 1'b0;
         o_return_addr <= 21'h001200;
      end
      else
      begin
         o_ret     <= i_ret_cmd;
         o_vec_ack <= i_vec.req && !o_vec_ack && wait_cnt >= i_ack_wait;
         wait_cnt  <= (i_vec.req && !o_vec_ack) ? wait_cnt + 4'h1 : 4'h0;
         if (o_ret)
         begin
            o_return_addr <= o_return_addr + 21'h000101;
         end
      end
   end
endmodule

// [dv/tb_two_level_priority_interrupt_unit.sv]
// tb_two_level_priority_interrupt_unit: self-checking bench.
// assumes: one apb wait state at most, core model acks vectors.
`timescale 1ns/100ps
module tb_two_level_priority_interrupt_unit;
   import tlpiu_pkg::*;
   logic          i_mclk = 1'b0;
   logic          i_arst_n = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0;
   logic [31:0]   o_prdata;
   logic          o_pready;
   logic          o_pslverr;
   logic [2:0]    ext_pin = 3'h0;
   logic [7:0]    per_ev = 8'h00;
   logic [20:0]   ret_addr;
   logic          vec_ack;
   logic          ret_op;
   tlpiu_vec_type o_vec;
   logic          o_stack_push;
   logic [20:0]   o_stack_data;
   logic [3:0]    ack_wait = 4'h0;
   logic          ret_cmd = 1'b0;
   int            err_count = 0;
   int            total_checks = 0;
   int            cyc = 0;

   tlpiu_top #(.NPER(8)) DUT (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_ext_pin(ext_pin),
      .i_periph_event(per_ev), .i_return_addr(ret_addr),
      .i_vec_ack(vec_ack), .i_return_from_irq_op(ret_op),
      .o_vec(o_vec), .o_stack_push(o_stack_push),
      .o_stack_data(o_stack_data));

   tlpiu_core_model core (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
      .i_vec(o_vec), .i_ack_wait(ack_wait), .i_ret_cmd(ret_cmd),
      .o_vec_ack(vec_ack), .o_ret(ret_op), .o_return_addr(ret_addr));

   // ------------------------------------------------------------
   // clock, hang guard, shared tasks
   // ------------------------------------------------------------
   always #2.5 i_mclk = ~i_mclk;

   // whole run needs a few hundred cycles; far above that is a hang
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string m);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("FAIL %0t %s got %h exp %h", $time, m, seen, exp);
      end
   endtask

   // apb master: request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      n = 0;
      @(posedge i_mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_mclk);
      penable <= 1'b1;
      @(posedge i_mclk);
      while (o_pready !== 1'b1 && n < 16)
      begin
         @(posedge i_mclk);
         n++;
      end
      if (o_pready !== 1'b1)
      begin
         err_count++;
         $display("FAIL %0t apb answer missing", $time);
      end
      rd = o_prdata;
      er = o_pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, {24'h0, d}, "register read");
   endtask

   task automatic pin();
      @(posedge i_mclk);
      ext_pin <= 3'h1;
      @(posedge i_mclk);
      ext_pin <= 3'h0;
   endtask

   task automatic pev();
      @(posedge i_mclk);
      per_ev <= 8'h01;
      @(posedge i_mclk);
      per_ev <= 8'h00;
   endtask

   // ask the core model for a return, then let it settle
   task automatic ret();
      @(posedge i_mclk);
      ret_cmd <= 1'b1;
      @(posedge i_mclk);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge i_mclk);
   endtask

   task automatic vec(input logic [20:0] a, output int lat);
      int n;
      lat = 0;
      n = 0;
      while (o_vec.req !== 1'b1 && lat < 40)
      begin
         @(posedge i_mclk);
         lat++;
      end
      chk(o_vec.req, 1, "vector raised");
      chk(o_vec.addr, a, "vector address");
      chk(o_vec.high, a == TLPIU_VEC_HIGH, "vector level");
      while (o_stack_push !== 1'b1 && n < 30)
      begin
         @(posedge i_mclk);
         n++;
      end
      chk(o_stack_push, 1, "stack push");
      chk(o_stack_data, ret_addr, "pushed return address");
      repeat (2) @(posedge i_mclk);
   endtask

   task automatic no_vec();
      logic seen;
      seen = 1'b0;
      repeat (24)
      begin
         @(posedge i_mclk);
         if (o_vec.req === 1'b1)
            seen = 1'b1;
      end
      chk(seen, 0, "vector not expected");
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      rd(TLPIU_OFF_EXT_CTRL, TLPIU_EXT_CTRL_RST);
      rd(TLPIU_OFF_RST_CTRL, 8'h00);
      rd(TLPIU_OFF_IRQ_CTRL, 8'h00);
      apb(1'b0, 12'h100, 32'h0, r, e);
      chk(e, 1, "unmapped error");
      $display("reset values done");
   endtask

   task automatic t_compat();
      int lat;
      wr(TLPIU_OFF_PER_EN, 8'h01);
      wr(TLPIU_OFF_EXT_CTRL, 8'hC8);
      wr(TLPIU_OFF_IRQ_CTRL, 8'h40);
      pin();
      no_vec();
      wr(TLPIU_OFF_EXT_CTRL, 8'hC8);
      wr(TLPIU_OFF_IRQ_CTRL, 8'h80);
      pev();
      no_vec();
      pin();
      vec(TLPIU_VEC_HIGH, lat);
      chk(lat >= 2 && lat <= 5, 1, "pin latency");
      rd(TLPIU_OFF_IRQ_CTRL, 8'h00);
      wr(TLPIU_OFF_EXT_CTRL, 8'hC8);
      ret();
      rd(TLPIU_OFF_IRQ_CTRL, 8'h80);
      wr(TLPIU_OFF_IRQ_CTRL, 8'hC0);
      vec(TLPIU_VEC_HIGH, lat);
      wr(TLPIU_OFF_PER_FLAG, 8'h00);
      ret();
      rd(TLPIU_OFF_IRQ_CTRL, 8'hC0);
      $display("compatibility mode done");
   endtask

   task automatic t_prio();
      int lat;
      ack_wait <= 4'h5;
      wr(TLPIU_OFF_RST_CTRL, 8'h80);
      pin();
      vec(TLPIU_VEC_HIGH, lat);
      rd(TLPIU_OFF_IRQ_CTRL, 8'h40);
      rd(TLPIU_OFF_STATUS, 8'h02);
      pev();
      no_vec();
      wr(TLPIU_OFF_EXT_CTRL, 8'hC8);
      ret();
      vec(TLPIU_VEC_LOW, lat);
      rd(TLPIU_OFF_IRQ_CTRL, 8'h80);
      pin();
      vec(TLPIU_VEC_HIGH, lat);
      rd(TLPIU_OFF_STATUS, 8'h03);
      wr(TLPIU_OFF_EXT_CTRL, 8'hC8);
      ret();
      rd(TLPIU_OFF_IRQ_CTRL, 8'h80);
      wr(TLPIU_OFF_PER_FLAG, 8'h00);
      ret();
      rd(TLPIU_OFF_IRQ_CTRL, 8'hC0);
      $display("priority mode done");
   endtask

   task automatic t_same();
      int lat;
      wr(TLPIU_OFF_IRQ_CTRL, 8'h00);
      pin();
      pev();
      rd(TLPIU_OFF_EXT_CTRL, 8'hC9);
      rd(TLPIU_OFF_PER_FLAG, 8'h01);
      wr(TLPIU_OFF_IRQ_CTRL, 8'hC0);
      vec(TLPIU_VEC_HIGH, lat);
      wr(TLPIU_OFF_EXT_CTRL, 8'hC8);
      ret();
      vec(TLPIU_VEC_LOW, lat);
      wr(TLPIU_OFF_PER_FLAG, 8'h00);
      ret();
      rd(TLPIU_OFF_IRQ_CTRL, 8'hC0);
      $display("simultaneous requests done");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      t_regs();
      t_compat();
      t_prio();
      t_same();
      stop_test();
   end
endmodule
